/* File: pkg/phs_pkg.sv */
// Constants, field layouts and carrier types for the header, scrambler and RS encode block.
// Assumes a single 125 MHz core clock; imported whole by the design.
package phs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TRAIN = 5'h04;
  localparam logic [4:0] ADDR_SEGLEN = 5'h08;
  localparam logic [4:0] ADDR_HDRCFG = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam int CTRL_MIDAMBLE = 0;
  localparam int CTRL_FRAGMENT = 1;
  localparam int CTRL_DISCOVERY = 2;
  localparam int CTRL_BEACON = 3;
  localparam int CTRL_REP_LSB = 4;
  localparam int TRAIN_RX_LSB = 0;
  localparam int TRAIN_TX_LSB = 8;
  localparam int HDRCFG_NSEG_LSB = 0;
  localparam int HDRCFG_ATIF = 8;
  localparam int HDRCFG_NMAC_LSB = 16;
  localparam int STATUS_SEED_LSB = 0;
  localparam int STATUS_BUSY = 4;
  localparam int STATUS_REPERR = 5;
  localparam int STATUS_PAD_LSB = 8;
  localparam logic [3:0] REP_RESERVED_MIN = 4'h8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Scrambler seeds, bit 0 is the first delay stage output
  // ----------------------------------------------------------------
  localparam logic [1:0] SEED_ID_RESET = 2'h0;
  localparam logic [3:0][14:0] SEED_TABLE = {15'h7fff, 15'h7ffd, 15'h7ffe, 15'h7ffc};

  // ----------------------------------------------------------------
  // Reed-Solomon and padding figures
  // ----------------------------------------------------------------
  localparam int RS_PARITY_OCTETS = 16;
  localparam int PAD_BLOCK_BITS = 1792;
  localparam logic [7:0] PAY_DATA_OCTETS = 8'(PAD_BLOCK_BITS / 8);
  localparam int PAY_PAD_OCTETS = 15;
  localparam int HDR_PAD_BASE = 237;
  localparam logic [7:0] GF_POLY_LOW = 8'h1d;
  localparam logic [7:0] GF_ALPHA = 8'h02;
  localparam logic [3:0] PARITY_LAST = 4'hf;

  function automatic logic [7:0] phs_gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] s;
    p = 8'h00;
    s = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) p = p ^ s;
      s = {s[6:0], 1'b0} ^ (s[7] ? GF_POLY_LOW : 8'h00);
    end
    return p;
  endfunction : phs_gf_mul

  // Generator coefficients, product of (x - alpha^i) for i = 0..15
  function automatic logic [16:0][7:0] phs_gen_poly();
    logic [16:0][7:0] g;
    logic [7:0] r;
    g = '0;
    g[0] = 8'h01;
    r = 8'h01;
    for (int i = 0; i < RS_PARITY_OCTETS; i++)
    begin
      for (int j = 16; j > 0; j--) g[j] = g[j-1] ^ phs_gf_mul(g[j], r);
      g[0] = phs_gf_mul(g[0], r);
      r = phs_gf_mul(r, GF_ALPHA);
    end
    return g;
  endfunction : phs_gen_poly

  localparam logic [16:0][7:0] RS_GEN = phs_gen_poly();

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] octet;
    logic scramble;
    logic hdr_start;
    logic seg_start;
    logic payload;
    logic cw_last;
    logic frame_last;
  } phs_in_t;

  typedef struct packed {
    logic [7:0] octet;
    logic [3:0][1:0] branch;
    logic parity;
    logic last;
  } phs_out_t;

  typedef struct packed {
    logic midamble_present_flag;
    logic fragment_follow_flag;
    logic [3:0] discovery_repeat_code;
    logic [5:0] rx_training_symbol_count;
    logic [5:0] tx_training_symbol_count;
    logic [15:0] segment_length;
    logic [7:0] shortening_pad_count;
  } phs_hdr_t;

endpackage : phs_pkg

/* File: rtl/phs_header_scramble_rs_encode.sv */
// Header field former, side-stream scrambler, zero padder and shortened RS(255,239) encoder.
// Assumes MAC logic on CORE_CLK and an Avalon-MM master on the same clock.
//
// Notes on behaviour
// - Midamble flag is 1 when a midamble follows the segment, else 0.
// - Fragment flag is 1 for a fragment to reassemble, 0 otherwise.
// - Repeat code n gives 2^n repetitions; codes 8 to 15 are refused.
// - Non-discovery frames carry repeat code 0000.
// - Receive training count is six bits, zero in a discovery beacon.
// - Transmit training count is six bits, zero in a discovery beacon.
// - Scrambled payload is zero padded to a whole multiple of 1792 bits.
// - Coded octets are split into four branches for later stages.
// - Only MAC header, check sequence and payload bits are scrambled.
// - Seed loads at MAC header start and reloads at each segment start.
// - Fifteen-stage register; new bit is stage 14 xor stage 15.
// - First seed bit sets stage one, last sets stage fifteen.
// - Each scrambled bit is input bit xor sequence bit.
// - Two-bit seed id clears at reset, wraps up once per frame.
// - Seed id selects one of four fixed fifteen-bit seeds.
// - Seeds yield the documented first sixteen sequence bits.
// - Shortened systematic RS appends 16 parity octets, highest first.
// - Payload codewords carry 224 data octets, shortening pad 15.
// - Header pad is 237 - 4*segments - 3*indicator - MAC header length.
// - Field arithmetic over GF(2^8), polynomial z^8+z^4+z^3+z^2+1.
// - Generator is product of (x - alpha^i), i 0..15, alpha 02.
// - Parity is x^16 m(x) mod g(x), first octet highest order.
// - Segment length is a sixteen-bit uncoded octet count.
`timescale 1ns/1ns
`default_nettype none

module phs_header_scramble_rs_encode
  import phs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic IN_VALID,
  input wire phs_in_t IN_DATA,
  output logic IN_READY,
  output logic OUT_VALID,
  output phs_out_t OUT_DATA,
  output phs_hdr_t HDR_FIELDS
);

  typedef enum logic [1:0] {ST_DATA, ST_PAD, ST_PARITY} phs_state_t;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] train_q;
  logic [31:0] seglen_q;
  logic [31:0] hdrcfg_q;
  logic rep_err_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] wmask;
  logic [31:0] ctrl_new;
  logic bus_wr;
  logic [1:0] seed_id_q;
  logic [7:0] pad_count;
  phs_state_t state_q;
  phs_state_t state_d;

  assign bus_wr = AVS_WRITE && !wait_q;

  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_mask
      assign wmask[8*b +: 8] = {8{AVS_BYTEENABLE[b]}};
    end
  endgenerate

  assign ctrl_new = (AVS_WRITEDATA & wmask) | (ctrl_q & ~wmask);

  // Wait state for one cycle, answer on the next
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST) wait_q <= 1'b1;
    else if (CLK_EN) wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST) rdata_q <= RESET_WORD;
    else if (CLK_EN && AVS_READ && wait_q)
    begin
      case (AVS_ADDRESS)
        ADDR_CTRL: rdata_q <= ctrl_q;
        ADDR_TRAIN: rdata_q <= train_q;
        ADDR_SEGLEN: rdata_q <= seglen_q;
        ADDR_HDRCFG: rdata_q <= hdrcfg_q;
        ADDR_STATUS:
        begin
          rdata_q <= RESET_WORD;
          rdata_q[STATUS_SEED_LSB +: 2] <= seed_id_q;
          rdata_q[STATUS_BUSY] <= (state_q != ST_DATA);
          rdata_q[STATUS_REPERR] <= rep_err_q;
          rdata_q[STATUS_PAD_LSB +: 8] <= pad_count;
        end
        default: rdata_q <= RESET_WORD;
      endcase
    end
  end

  // Reserved repeat codes keep the previous code and flag an error
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctrl_q <= RESET_WORD;
      train_q <= RESET_WORD;
      seglen_q <= RESET_WORD;
      hdrcfg_q <= RESET_WORD;
      rep_err_q <= 1'b0;
    end
    else if (CLK_EN && bus_wr)
    begin
      case (AVS_ADDRESS)
        ADDR_CTRL:
        begin
          if (ctrl_new[CTRL_REP_LSB +: 4] >= REP_RESERVED_MIN)
          begin
            ctrl_q[CTRL_REP_LSB - 1:0] <= ctrl_new[CTRL_REP_LSB - 1:0];
            rep_err_q <= 1'b1;
          end
          else ctrl_q <= ctrl_new;
        end
        ADDR_TRAIN: train_q <= (AVS_WRITEDATA & wmask) | (train_q & ~wmask);
        ADDR_SEGLEN: seglen_q <= (AVS_WRITEDATA & wmask) | (seglen_q & ~wmask);
        ADDR_HDRCFG: hdrcfg_q <= (AVS_WRITEDATA & wmask) | (hdrcfg_q & ~wmask);
        ADDR_STATUS:
        begin
          if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[STATUS_REPERR]) rep_err_q <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;

  // ----------------------------------------------------------------
  // Header fields
  // ----------------------------------------------------------------
  logic [9:0] pad_wide;

  assign pad_wide = 10'(HDR_PAD_BASE) - {2'h0, hdrcfg_q[HDRCFG_NSEG_LSB +: 6], 2'h0}
    - (hdrcfg_q[HDRCFG_ATIF] ? 10'h003 : 10'h000)
    - {2'h0, hdrcfg_q[HDRCFG_NMAC_LSB +: 8]};
  assign pad_count = pad_wide[7:0];

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST) HDR_FIELDS <= '0;
    else if (CLK_EN)
    begin
      HDR_FIELDS.midamble_present_flag <= ctrl_q[CTRL_MIDAMBLE];
      HDR_FIELDS.fragment_follow_flag <= ctrl_q[CTRL_FRAGMENT];
      HDR_FIELDS.discovery_repeat_code <=
        ctrl_q[CTRL_DISCOVERY] ? ctrl_q[CTRL_REP_LSB +: 4] : 4'h0;
      HDR_FIELDS.rx_training_symbol_count <=
        ctrl_q[CTRL_BEACON] ? 6'h00 : train_q[TRAIN_RX_LSB +: 6];
      HDR_FIELDS.tx_training_symbol_count <=
        ctrl_q[CTRL_BEACON] ? 6'h00 : train_q[TRAIN_TX_LSB +: 6];
      HDR_FIELDS.segment_length <= seglen_q[15:0];
      HDR_FIELDS.shortening_pad_count <= pad_count;
    end
  end

  // ----------------------------------------------------------------
  // Scrambler
  // ----------------------------------------------------------------
  // Returns next state in [22:8] and coded octet in [7:0]
  function automatic logic [22:0] phs_scramble(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    logic x;
    s = st;
    o = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      x = s[13] ^ s[14];
      o[k] = d[k] ^ x;
      s = {s[13:0], x};
    end
    return {s, o};
  endfunction : phs_scramble

  logic [14:0] scr_q;
  logic [14:0] scr_base;
  logic [22:0] scr_res;
  logic [7:0] coded;
  logic accept;
  logic frame_end_q;
  logic [7:0] cnt_q;
  logic [3:0] par_cnt_q;

  assign accept = IN_VALID && IN_READY && (state_q == ST_DATA);
  assign scr_base = (IN_DATA.hdr_start || IN_DATA.seg_start)
    ? SEED_TABLE[seed_id_q] : scr_q;
  assign scr_res = phs_scramble(scr_base, IN_DATA.octet);
  assign coded = IN_DATA.scramble ? scr_res[7:0] : IN_DATA.octet;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST) scr_q <= SEED_TABLE[SEED_ID_RESET];
    else if (CLK_EN && accept)
      scr_q <= IN_DATA.scramble ? scr_res[22:8] : scr_base;
  end

  // Seed id advances after the last codeword of each frame
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST) seed_id_q <= SEED_ID_RESET;
    else if (CLK_EN && state_q == ST_PARITY && par_cnt_q == PARITY_LAST && frame_end_q)
      seed_id_q <= seed_id_q + 2'h1;
  end

  // ----------------------------------------------------------------
  // Reed-Solomon encoder
  // ----------------------------------------------------------------
  logic [15:0][7:0] par_q;
  logic [15:0][7:0] par_next;
  logic [7:0] rs_in;
  logic [7:0] feedback;

  // Zero octets ahead of the data leave a cleared remainder unchanged, so
  // the shortening pad needs no cycles of its own.
  assign rs_in = (state_q == ST_PAD) ? 8'h00 : coded;
  assign feedback = rs_in ^ par_q[15];

  genvar j;
  generate
    for (j = 0; j < RS_PARITY_OCTETS; j++)
    begin : g_rs
      if (j == 0)
      begin : g_first
        assign par_next[j] = phs_gf_mul(feedback, RS_GEN[j]);
      end
      else
      begin : g_rest
        assign par_next[j] = par_q[j-1] ^ phs_gf_mul(feedback, RS_GEN[j]);
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST) par_q <= '0;
    else if (CLK_EN)
    begin
      if (accept || state_q == ST_PAD) par_q <= par_next;
      else if (state_q == ST_PARITY) par_q <= {par_q[14:0], 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [7:0] cnt_inc;

  assign cnt_inc = cnt_q + 8'h01;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_DATA:
      begin
        if (accept && IN_DATA.payload && cnt_inc == PAY_DATA_OCTETS) state_d = ST_PARITY;
        else if (accept && IN_DATA.payload && IN_DATA.cw_last) state_d = ST_PAD;
        else if (accept && IN_DATA.cw_last) state_d = ST_PARITY;
      end
      ST_PAD:
      begin
        if (cnt_inc == PAY_DATA_OCTETS) state_d = ST_PARITY;
      end
      ST_PARITY:
      begin
        if (par_cnt_q == PARITY_LAST) state_d = ST_DATA;
      end
      default: state_d = ST_DATA;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q <= ST_DATA;
      IN_READY <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_q <= state_d;
      IN_READY <= (state_d == ST_DATA);
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cnt_q <= 8'h00;
      par_cnt_q <= 4'h0;
      frame_end_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (state_d == ST_PARITY || state_q == ST_PARITY) cnt_q <= 8'h00;
      else if ((accept && IN_DATA.payload) || state_q == ST_PAD) cnt_q <= cnt_inc;
      par_cnt_q <= (state_q == ST_PARITY) ? par_cnt_q + 4'h1 : 4'h0;
      if (accept && IN_DATA.frame_last) frame_end_q <= 1'b1;
      else if (state_q == ST_PARITY && par_cnt_q == PARITY_LAST) frame_end_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output stage with four-branch split, octet bit 0 sent first
  // ----------------------------------------------------------------
  logic [7:0] out_octet;
  logic [3:0][1:0] branch;

  assign out_octet = (state_q == ST_PARITY) ? par_q[15] : rs_in;

  genvar m;
  generate
    for (m = 0; m < 4; m++)
    begin : g_branch
      assign branch[m] = {out_octet[m + 4], out_octet[m]};
    end
  endgenerate

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      OUT_VALID <= 1'b0;
      OUT_DATA <= '0;
    end
    else if (CLK_EN)
    begin
      OUT_VALID <= accept || state_q != ST_DATA;
      OUT_DATA.octet <= out_octet;
      OUT_DATA.branch <= branch;
      OUT_DATA.parity <= (state_q == ST_PARITY);
      OUT_DATA.last <= (state_q == ST_PARITY) && par_cnt_q == PARITY_LAST && frame_end_q;
    end
  end

endmodule : phs_header_scramble_rs_encode

`default_nettype wire

/* File: testbench/phs_properties.sv */
// Concurrent checks on the ports of the header, scrambler and RS encoder top.
// Assumes one clock domain and binding from the testbench top file.
`timescale 1ns/1ns
`default_nettype none

module phs_properties
  import phs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic OUT_VALID,
  input wire phs_out_t OUT_DATA,
  input wire phs_hdr_t HDR_FIELDS
);
  // ----------------------------------------------------------------
  // Length of the current parity run
  // ----------------------------------------------------------------
  logic [4:0] par_q;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      par_q <= 5'h00;
    else if (OUT_VALID && OUT_DATA.parity)
      par_q <= par_q + 5'h01;
    else
      par_q <= 5'h00;
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN |=>
    !AVS_WAITREQUEST) else $error("bus request not answered next cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  unmapped_read_a: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS > ADDR_STATUS
    |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  reserved_code_a: assert property (HDR_FIELDS.discovery_repeat_code < REP_RESERVED_MIN)
    else $error("reserved repeat code in header");
  stream_answer_a: assert property (IN_VALID && IN_READY |=> OUT_VALID && !OUT_DATA.parity)
    else $error("taken octet not passed on next cycle");
  branch_split_a: assert property (OUT_VALID |-> OUT_DATA.branch == {OUT_DATA.octet[7],
    OUT_DATA.octet[3], OUT_DATA.octet[6], OUT_DATA.octet[2], OUT_DATA.octet[5],
    OUT_DATA.octet[1], OUT_DATA.octet[4], OUT_DATA.octet[0]}) else $error("branch split wrong");
  parity_run_a: assert property (!(OUT_VALID && OUT_DATA.parity) && par_q != 5'h00 |->
    par_q == 5'h10) else $error("parity run not sixteen octets");
  parity_refuse_a: assert property (OUT_VALID && OUT_DATA.parity && par_q < 5'h0e |-> !IN_READY)
    else $error("input ready during parity");
  last_parity_a: assert property (OUT_VALID && OUT_DATA.last |->
    OUT_DATA.parity && par_q == 5'h0f) else $error("last flag not on final parity");

  cover property (OUT_VALID && OUT_DATA.last);
  cover property (!AVS_WAITREQUEST && AVS_WRITE);
  cover property (IN_VALID && !IN_READY);
  cover property (OUT_VALID && !OUT_DATA.parity && !IN_READY && !CLK_EN);
endmodule : phs_properties

`default_nettype wire

/* File: testbench/phs_mac_model.sv */
// MAC side model: offers octets of one codeword with their framing flags.
// Assumes the caller fills tx_q with {scramble, octet} before calling send.
`timescale 1ns/1ns
`default_nettype none

module phs_mac_model
  import phs_pkg::*;
(
  input wire logic clk,
  input wire logic in_ready,
  output logic in_valid,
  output phs_in_t in_data
);
  logic [8:0] tx_q [$];
  int hang = 0;

  initial
  begin
    in_valid = 1'b0;
    in_data = '0;
  end

  // Gap gives a slow MAC; idle data shows the inverse of the last octet
  task automatic send(input logic hdr, input logic seg, input logic pay, input logic fl,
                      input int gap);
    phs_in_t d;
    int n;
    int w;
    n = tx_q.size();
    for (int i = 0; i < n; i++)
    begin
      d = '{octet: tx_q[i][7:0], scramble: tx_q[i][8], hdr_start: hdr && i == 0,
            seg_start: seg && i == 0, payload: pay, cw_last: i == n - 1 && n < 224,
            frame_last: fl && i == n - 1};
      in_data <= d;
      in_valid <= 1'b1;
      w = 0;
      @(posedge clk);
      while (in_ready !== 1'b1 && w < 600)
      begin
        w++;
        @(posedge clk);
      end
      if (w >= 600) hang++;
      if (gap > 0 || i == n - 1)
      begin
        in_valid <= 1'b0;
        in_data <= ~d;
        repeat (gap) @(posedge clk);
      end
    end
  endtask : send
endmodule : phs_mac_model

`default_nettype wire

/* File: testbench/test_phs_header_scramble_rs_encode.sv */
// Self-checking bench: register bus, header fields and coded octet stream.
// Assumes the MAC model drives the stream input; checker bound at the foot.
`timescale 1ns/1ns
`default_nettype none

module test_phs_header_scramble_rs_encode
  import phs_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CLK_EN = 1'b1;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, IN_VALID, IN_READY, OUT_VALID;
  phs_in_t IN_DATA;
  phs_out_t OUT_DATA;
  phs_hdr_t HDR_FIELDS;
  int seed = 62039;
  int n_fail = 0;
  int cmp_count = 0;
  logic [1:0] sid = 2'h0;
  logic [14:0] lf;
  logic [7:0] gen [17];
  logic [9:0] got [$];
  logic [3:0] rep_q = 4'h0;
  logic [15:0] pats [4] = '{16'h0010, 16'h0020, 16'h0070, 16'h0040};

  always #4 CORE_CLK = ~CORE_CLK;

  phs_header_scramble_rs_encode i_dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .HDR_FIELDS(HDR_FIELDS));
  phs_mac_model i_mac (.clk(CORE_CLK), .in_ready(IN_READY), .in_valid(IN_VALID),
    .in_data(IN_DATA));

  always @(posedge CORE_CLK)
    if (OUT_VALID === 1'b1 && CLK_EN) got.push_back({OUT_DATA.last, OUT_DATA.parity, OUT_DATA.octet});

  // ----------------------------------------------------------------
  // Checking, bus and reference tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic hang_out;
    n_fail++;
    wrap_up();
  endtask : hang_out

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int w;
    w = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    @(posedge CORE_CLK);
    while (AVS_WAITREQUEST !== 1'b0)
    begin
      w++;
      if (w > 40) hang_out();
      @(posedge CORE_CLK);
    end
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CORE_CLK);
  endtask : bus

  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
    end
    return p;
  endfunction : gm

  function automatic logic [14:0] seed_of(input logic [1:0] id);
    return {13'h1fff, id[0], id[1]};
  endfunction : seed_of

  task automatic hdr_test;
    logic [31:0] c, r, s, rd;
    phs_hdr_t e;
    for (int k = 0; k < 16; k++)
    begin
      r = $random(seed);
      s = $random(seed);
      c = {24'h0, 4'(k), r[3:0]};
      if (k < 8) rep_q = 4'(k);
      bus(1'b1, ADDR_CTRL, c, rd);
      bus(1'b1, ADDR_TRAIN, {18'h0, r[13:8], 2'h0, r[5:0]}, rd);
      bus(1'b1, ADDR_SEGLEN, {16'h0, s[31:16]}, rd);
      bus(1'b1, ADDR_HDRCFG, {8'h0, 1'b0, s[6:0], 7'h0, s[7], 4'h0, s[11:8]}, rd);
      e = '{c[0], c[1], c[2] ? rep_q : 4'h0, c[3] ? 6'h0 : r[5:0], c[3] ? 6'h0 : r[13:8],
            s[31:16], 8'(237 - 4 * s[11:8] - 3 * s[7] - s[6:0])};
      repeat (2) @(posedge CORE_CLK);
      chk("hdr_fields", HDR_FIELDS, e);
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      chk("rep_err", rd[5], k > 7);
      chk("pad_count", rd[15:8], e.shortening_pad_count);
      chk("seed_id", rd[1:0], sid);
      if (rd[5]) bus(1'b1, ADDR_STATUS, 32'h20, rd);
    end
  endtask : hdr_test

  task automatic cw(input int n, input logic hdr, input logic seg, input logic pay,
                    input logic fl, input logic zero, input int gap);
    logic [7:0] d, o, fb;
    logic [7:0] par [16];
    logic [9:0] e [$];
    logic sc;
    int m, w;
    par = '{default: 8'h00};
    got.delete();
    i_mac.tx_q.delete();
    if (hdr || seg) lf = seed_of(sid);
    for (int i = 0; i < (pay ? 224 : n); i++)
    begin
      m = $random(seed);
      d = (zero || i >= n) ? 8'h00 : m[7:0];
      sc = pay || zero || m[8];
      o = d;
      if (i < n) i_mac.tx_q.push_back({sc, d});
      for (int b = 0; b < 8 && sc && i < n; b++)
      begin
        o[b] = d[b] ^ lf[13] ^ lf[14];
        lf = {lf[13:0], lf[13] ^ lf[14]};
      end
      e.push_back({2'b00, o});
      fb = o ^ par[15];
      for (int j = 15; j > 0; j--) par[j] = par[j-1] ^ gm(fb, gen[j]);
      par[0] = gm(fb, gen[0]);
    end
    for (int j = 15; j >= 0; j--) e.push_back({fl && j == 0, 1'b1, par[j]});
    if (fl) sid++;
    i_mac.send(hdr, seg, pay, fl, gap);
    // Freeze during zero padding; no octet may be lost or repeated
    if (pay && n < 224)
    begin
      CLK_EN <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      CLK_EN <= 1'b1;
    end
    w = 0;
    while (got.size() < e.size())
    begin
      w++;
      if (w > 600) hang_out();
      @(posedge CORE_CLK);
    end
    repeat (2) @(posedge CORE_CLK);
    chk("octet_count", got.size(), e.size());
    foreach (e[i]) chk("coded_octet", got[i], e[i]);
  endtask : cw

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] a;
    logic [31:0] rd;
    gen = '{default: 8'h00};
    gen[0] = 8'h01;
    a = 8'h01;
    for (int i = 0; i < 16; i++)
    begin
      for (int j = 16; j > 0; j--) gen[j] = gen[j-1] ^ gm(gen[j], a);
      gen[0] = gm(gen[0], a);
      a = gm(a, 8'h02);
    end
    repeat (3) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    chk("hdr_reset", HDR_FIELDS, 64'h0);
    for (int i = 0; i < 4; i++)
    begin
      cw(2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 0);
      chk("prbs_head", {got[0][7:0], got[1][7:0]}, pats[i]);
    end
    $display("seed test done");
    hdr_test();
    bus(1'b0, 5'h14, 32'h0, rd);
    chk("unmapped", rd, 64'h0);
    bus(1'b1, ADDR_SEGLEN, 32'h5a5a_5a5a, rd);
    AVS_BYTEENABLE <= 4'h2;
    bus(1'b1, ADDR_SEGLEN, 32'h0000_c300, rd);
    AVS_BYTEENABLE <= 4'hf;
    bus(1'b0, ADDR_SEGLEN, 32'h0, rd);
    chk("lane_write", rd, 64'h5a5a_c35a);
    $display("register test done");
    for (int i = 0; i < 3; i++)
    begin
      cw(1 + {$random(seed)} % 20, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, i);
      cw(1 + {$random(seed)} % 30, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, i);
      cw(224, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 0);
    end
    chk("mac_stall", i_mac.hang, 64'h0);
    $display("stream test done");
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge CORE_CLK);
    hang_out();
  end
endmodule : test_phs_header_scramble_rs_encode

bind phs_header_scramble_rs_encode phs_properties i_props (.CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
  .HDR_FIELDS(HDR_FIELDS));

`default_nettype wire
